// ===== rtl/rsd_pkg.sv
// Package with opcode encodings, widths and carrier types for the rotate and fill datapath.
package rsd_pkg;
    // ==========================================
    // Widths and encodings
    // ==========================================
    localparam int RSD_W = 8;
    localparam logic [7:0] RSD_ALL_ONES = 8'hFF;
    localparam logic [7:0] RSD_ZERO = 8'h00;
    localparam logic [6:0] RSD_OPC_ROT_RIGHT_PLAIN = 7'h10;
    localparam logic [6:0] RSD_OPC_FILL_ONES = 7'h15;
    localparam int RSD_MSB = 7;
    localparam int RSD_LSB = 0;

    // ==========================================
    // Instruction word fields
    // ==========================================
    localparam int RSD_OPC_HI = 15;
    localparam int RSD_OPC_LO = 9;
    localparam int RSD_DBIT = 8;
    localparam int RSD_ADDR_HI = 7;
    localparam int RSD_ADDR_LO = 0;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } rsd_instr_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] data;
    } rsd_fwrite_t;
endpackage : rsd_pkg

// ===== rtl/rsd_datapath.sv
// Execute datapath for the plain rotate-right and fill-with-ones instructions.
`timescale 1ns/1ps
`default_nettype none
module rsd_datapath (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire rsd_pkg::rsd_instr_t i_instr,
    input wire logic [7:0] i_file_data,
    input wire logic [7:0] i_status,
    output logic [7:0] o_file_addr,
    output rsd_pkg::rsd_fwrite_t o_fwrite,
    output logic [7:0] o_acc,
    output logic [7:0] o_status,
    output logic o_done
);
    import rsd_pkg::*;

    // ==========================================
    // Instruction field split
    // ==========================================
    // The opcode, the destination or scope bit and the file address are cut
    // from the instruction word once, so that the rest of the block reads
    // names rather than bit positions.
    wire logic [6:0] opc = i_instr.word[RSD_OPC_HI:RSD_OPC_LO];
    wire logic dbit = i_instr.word[RSD_DBIT];
    wire logic [7:0] faddr = i_instr.word[RSD_ADDR_HI:RSD_ADDR_LO];
    wire logic instr_valid = i_instr.valid;

    // The file is read combinationally in the same cycle, so the read
    // address follows the instruction word with no register in between.
    assign o_file_addr = faddr;

    // ==========================================
    // Opcode decode
    // ==========================================
    // Any other opcode, or an empty instruction slot, leaves the file write enable
    // and the completion flag idle and the accumulator untouched.
    wire logic opc_rot = (opc == RSD_OPC_ROT_RIGHT_PLAIN);
    wire logic opc_fill = (opc == RSD_OPC_FILL_ONES);
    wire logic is_rot = instr_valid && opc_rot;
    wire logic is_fill = instr_valid && opc_fill;
    wire logic is_ours = is_rot || is_fill;

    // ==========================================
    // Rotate right without carry
    // ==========================================
    // Each result bit takes the operand bit one place above it, and the top
    // bit takes the old bit 0, so no carry enters or leaves the word.
    logic [7:0] rot_val;
    for (genvar g = 0; g < RSD_W; g++) begin : g_rot
        assign rot_val[g] = i_file_data[(g + 1) % RSD_W];
    end

    // ==========================================
    // Destination steering
    // ==========================================
    // The rotate goes either to the accumulator or back to the file, never
    // both. A fill always writes the file and writes the accumulator too
    // only when its scope bit is clear.
    wire logic rot_to_file = is_rot && dbit;
    wire logic rot_to_acc = is_rot && !dbit;
    wire logic fill_both = is_fill && !dbit;
    wire logic fill_file = is_fill && dbit;

    wire logic f_we = rot_to_file || is_fill;
    wire logic [7:0] f_val = is_fill ? RSD_ALL_ONES : rot_val;
    wire logic acc_we = rot_to_acc || fill_both;
    wire logic [7:0] acc_val = is_fill ? RSD_ALL_ONES : rot_val;

    // The whole write request is formed here so the register below only
    // has to capture it.
    rsd_fwrite_t next_fwrite;
    assign next_fwrite = '{we: f_we, addr: faddr, data: f_val};

    // The accumulator keeps its value unless this cycle's instruction names
    // it as a destination.
    logic [7:0] acc;
    wire logic [7:0] next_acc = acc_we ? acc_val : acc;

    // ==========================================
    // Accumulator register
    // ==========================================
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            acc <= RSD_ZERO;
        end else begin
            acc <= next_acc;
        end
    end
    assign o_acc = acc;

    // ==========================================
    // File write request register
    // ==========================================
    // The write enable stands for one cycle after each instruction that
    // writes the file, and again only if the next instruction does so too.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_fwrite <= '0;
        end else begin
            o_fwrite <= next_fwrite;
        end
    end

    // ==========================================
    // Completion pulse
    // ==========================================
    // Both instructions finish in the cycle after they are taken, so the
    // completion flag is simply the registered decode.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_done <= 1'b0;
        end else begin
            o_done <= is_ours;
        end
    end

    // ==========================================
    // Status pass-through
    // ==========================================
    // Neither instruction touches a flag, so the status word is carried
    // through unchanged with the same one-cycle latency as the results.
    logic [7:0] status;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            status <= RSD_ZERO;
        end else begin
            status <= i_status;
        end
    end
    assign o_status = status;

    // ==========================================
    // Checks
    // ==========================================
    // The expected rotate result is built here from a concatenation, apart
    // from the per-bit loop above, so a slip in either one shows.
    a_rot_value: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        rot_to_file |=> o_fwrite.data == {$past(i_file_data[RSD_LSB]),
        $past(i_file_data[RSD_MSB:1])})
        else $error("rotate result wrong");

    a_rot_to_acc: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        rot_to_acc |=> !o_fwrite.we && o_acc == {$past(i_file_data[RSD_LSB]),
        $past(i_file_data[RSD_MSB:1])})
        else $error("rotate to accumulator wrong");

    a_rot_to_file: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        rot_to_file |=> o_fwrite.we && o_fwrite.addr == $past(faddr) && $stable(o_acc))
        else $error("rotate to file wrong");

    a_fill_both: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fill_both |=> o_fwrite.we && o_fwrite.data == RSD_ALL_ONES && o_acc == RSD_ALL_ONES)
        else $error("fill both wrong");

    a_fill_file_only: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fill_file |=> o_fwrite.we && o_fwrite.data == RSD_ALL_ONES && $stable(o_acc))
        else $error("fill file only wrong");

    a_fill_address: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        is_fill |=> o_fwrite.addr == $past(faddr))
        else $error("fill address wrong");

    a_one_cycle: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        is_ours |=> o_done)
        else $error("instruction not done in one cycle");

    a_status_kept: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        1'b1 |=> o_status == $past(i_status))
        else $error("status altered");

    a_idle_quiet: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        !is_ours |=> !o_fwrite.we && !o_done && $stable(o_acc))
        else $error("write without instruction");

    a_read_address: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        o_file_addr == i_instr.word[RSD_ADDR_HI:RSD_ADDR_LO])
        else $error("read address wrong");

    // ==========================================
    // Coverage of the main scenarios
    // ==========================================
    c_rot_acc: cover property (@(posedge i_clk) disable iff (!i_rst_n) rot_to_acc);
    c_rot_file: cover property (@(posedge i_clk) disable iff (!i_rst_n) rot_to_file);
    c_fill_both: cover property (@(posedge i_clk) disable iff (!i_rst_n) fill_both);
    c_fill_file: cover property (@(posedge i_clk) disable iff (!i_rst_n) fill_file);
    c_back_to_back: cover property (@(posedge i_clk) disable iff (!i_rst_n)
        is_rot ##1 is_fill);
endmodule : rsd_datapath
`default_nettype wire

// ===== verification/test_rsd_datapath.sv
// Self-checking random testbench for the rotate and fill datapath.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
    $display("mismatch %s expected %h seen %h", nm, e, g); n_errors++; end end
module test_rsd_datapath;
    import rsd_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    rsd_instr_t i_instr = '0;
    logic [7:0] i_file_data = 8'h00, i_status = 8'h00, o_file_addr, o_acc, o_status;
    rsd_fwrite_t o_fwrite;
    logic o_done, e_rot, e_fill, e_we, e_acc_wr;
    int n_errors = 0, total_checks = 0, seed = 99, k;
    logic [7:0] e_acc = 8'h00, e_data, e_st, e_prev;
    logic [6:0] op;
    rsd_instr_t cur;
    rsd_datapath dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_instr(i_instr),
        .i_file_data(i_file_data), .i_status(i_status), .o_file_addr(o_file_addr),
        .o_fwrite(o_fwrite), .o_acc(o_acc), .o_status(o_status), .o_done(o_done));
    initial forever #5 i_clk = ~i_clk;
    function automatic logic [7:0] rot(input logic [7:0] f);
        return {f[0], f[7:1]};
    endfunction : rot
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (2) @(posedge i_clk);
        `CHK("acc_rst", 8'h00, o_acc)
        i_rst_n <= 1'b1;
        for (int i = 0; i < 600; i++) begin
            @(posedge i_clk);
            cur = i_instr;
            e_rot = cur.valid && (cur.word[15:9] === RSD_OPC_ROT_RIGHT_PLAIN);
            e_fill = cur.valid && (cur.word[15:9] === RSD_OPC_FILL_ONES);
            e_data = e_fill ? RSD_ALL_ONES : rot(i_file_data);
            e_we = e_fill || (e_rot && cur.word[8]);
            e_acc_wr = (e_rot || e_fill) && !cur.word[8];
            e_prev = e_acc;
            if (e_acc_wr) e_acc = e_data;
            e_st = i_status;
            k = $unsigned($random(seed)) % 4;
            op = k == 0 ? RSD_OPC_ROT_RIGHT_PLAIN : k == 1 ? RSD_OPC_FILL_ONES : k == 2 ? 7'h11 : 7'($random(seed));
            i_instr <= (i == 0) ? {1'b1, 7'h10, 1'b1, 8'h3C} : {1'(i % 8 != 7), op, 9'($random(seed))};
            i_file_data <= (i == 0) ? 8'hD7 : 8'($random(seed));
            i_status <= 8'($random(seed));
            @(negedge i_clk);
            `CHK("done", e_rot || e_fill, o_done)
            `CHK("we", e_we, o_fwrite.we)
            if (e_we) `CHK("fdata", e_data, o_fwrite.data)
            if (e_we) `CHK("faddr", cur.word[7:0], o_fwrite.addr)
            `CHK("acc", e_acc, o_acc)
            `CHK("acc_keep", e_acc_wr ? e_data : e_prev, o_acc)
            `CHK("status", e_st, o_status)
            `CHK("raddr", i_instr.word[7:0], o_file_addr)
        end
        give_verdict();
    end
endmodule : test_rsd_datapath
`default_nettype wire
